// ---- src/rmc_consts.vh ----
// constants of the radio module command interpreter
`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH
`define RMC_SFD            8'hFF
`define RMC_CNF_BIT        8'h80
`define RMC_CMD_TX         8'h00
`define RMC_CMD_OBS_RETRY  8'h02
`define RMC_CMD_RX_IND     8'h03
`define RMC_CMD_MODE       8'h04
`define RMC_CMD_RESTART    8'h05
`define RMC_CMD_OBS_CHAN   8'h06
`define RMC_CMD_NV_WRITE   8'h09
`define RMC_CMD_NV_READ    8'h0A
`define RMC_CMD_UNIT_NO    8'h0B
`define RMC_CMD_FW_VER     8'h0C
`define RMC_CMD_SIG_LVL    8'h0D
`define RMC_CMD_RATE       8'h10
`define RMC_CMD_OBS_PRE    8'h30
`define RMC_CMD_OBS_CLR    8'h31
`define RMC_CMD_KEY_REG    8'h50
`define RMC_CMD_KEY_UNREG  8'h51
`define RMC_CMD_KEY_LIST   8'h52
`define RMC_ST_OK          8'h00
`define RMC_ST_FAIL        8'h01
`define RMC_ST_INVALID     8'h02
`define RMC_LEN_ONE        8'h01
`define RMC_LEN_MIN        8'h09
`define RMC_MODE_S1M       8'h02
`define RMC_MODE_S2        8'h03
`define RMC_MODE_T1M       8'h05
`define RMC_MODE_T2M       8'h07
`define RMC_MODE_T2O       8'h08
`define RMC_MODE_C2T2O     8'h09
`define RMC_MODE_C1M       8'h0C
`define RMC_MODE_C2M       8'h0D
`define RMC_MODE_C2O       8'h0E
`define RMC_CMD_OUT_ON     8'h01
// register map, byte addresses
`define RMC_REG_CTRL       8'h00
`define RMC_REG_STATUS     8'h04
`define RMC_REG_MODE       8'h08
`define RMC_REG_RESULT     8'h0C
`define RMC_REG_MAXLEN     8'h10
`define RMC_REG_CMDCNT     8'h14
`define RMC_CTRL_OUT_EN    0
`define RMC_CTRL_SIG_APP   1
`define RMC_CTRL_TX_FAIL   2
`define RMC_CTRL_RESET     8'h00
`define RMC_PRESEL_RESET   8'h03
`define RMC_MAXLEN_RESET   8'hF6
`define RMC_AXI_OKAY       2'b00
`define RMC_AXI_SLVERR     2'b10
`endif

// ---- src/rmc_frame_tx.v ----
// serialiser for confirmation and indication frames with xor checksum
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module rmc_frame_tx
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // frame request
  input  wire        start,
  input  wire [7:0]  code,
  input  wire [7:0]  len,
  input  wire        is_ind,
  input  wire        sig_app,
  input  wire [7:0]  status,
  input  wire [7:0]  sig_level,
  output wire        busy,
  output wire        done,
  // payload source for indications
  output reg  [7:0]  pay_idx_q,
  input  wire [7:0]  pay_byte,
  // byte stream out
  output reg  [7:0]  out_data_q,
  output reg         out_valid_q,
  input  wire        out_ready
);
  localparam S_IDLE = 6'b000001;
  localparam S_SFD  = 6'b000010;
  localparam S_CODE = 6'b000100;
  localparam S_LEN  = 6'b001000;
  localparam S_BODY = 6'b010000;
  localparam S_CS   = 6'b100000;
  reg [5:0] st_q;
  reg [7:0] cs_q;
  reg [7:0] body_q;
  reg       done_q;
  // request fields held for the whole frame: the sources move on after start
  reg [7:0] code_q;
  reg [7:0] len_q;
  reg [7:0] stat_q;
  reg       ind_q;
  wire      take = ~out_valid_q | out_ready;
  assign busy = (st_q != S_IDLE) | out_valid_q;
  assign done = done_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q        <= S_IDLE;
      cs_q        <= 8'h00;
      body_q      <= 8'h00;
      pay_idx_q   <= 8'h00;
      out_data_q  <= 8'h00;
      out_valid_q <= 1'b0;
      done_q      <= 1'b0;
      code_q      <= 8'h00;
      len_q       <= 8'h00;
      stat_q      <= 8'h00;
      ind_q       <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (out_valid_q && out_ready)
        out_valid_q <= 1'b0;
      case (st_q)
        S_IDLE:
          if (start)
          begin
            st_q      <= S_SFD;
            pay_idx_q <= 8'h00;
            body_q    <= is_ind ? (len + {7'h00, sig_app}) : len;
            code_q    <= code;
            len_q     <= len;
            stat_q    <= status;
            ind_q     <= is_ind;
          end
        S_SFD:
          if (take)
          begin
            out_data_q  <= `RMC_SFD;
            out_valid_q <= 1'b1;
            cs_q        <= `RMC_SFD;
            st_q        <= S_CODE;
          end
        S_CODE:
          if (take)
          begin
            out_data_q  <= code_q;
            out_valid_q <= 1'b1;
            cs_q        <= cs_q ^ code_q;
            st_q        <= S_LEN;
          end
        S_LEN:
          if (take)
          begin
            // indication length grows by one when the signal byte is appended
            out_data_q  <= body_q;
            out_valid_q <= 1'b1;
            cs_q        <= cs_q ^ body_q;
            st_q        <= (body_q == 8'h00) ? S_CS : S_BODY;
          end
        S_BODY:
          if (take)
          begin
            out_valid_q <= 1'b1;
            if (!ind_q)
            begin
              out_data_q <= stat_q;
              cs_q       <= cs_q ^ stat_q;
            end
            else if (pay_idx_q < len_q)
            begin
              out_data_q <= pay_byte;
              cs_q       <= cs_q ^ pay_byte;
            end
            else
            begin
              out_data_q <= sig_level;
              cs_q       <= cs_q ^ sig_level;
            end
            pay_idx_q <= pay_idx_q + 8'h01;
            if (pay_idx_q + 8'h01 == body_q)
              st_q <= S_CS;
          end
        S_CS:
          if (take)
          begin
            out_data_q  <= cs_q;
            out_valid_q <= 1'b1;
            done_q      <= 1'b1;
            st_q        <= S_IDLE;
          end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
endmodule // rmc_frame_tx
`default_nettype wire

// ---- src/rmc_cmd_interp.v ----
// command interpreter of the radio module serial interface
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module rmc_cmd_interp
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // host command byte stream in
  input  wire [7:0]  host_rx_data,
  input  wire        host_rx_valid,
  output wire        host_rx_ready,
  // host answer byte stream out
  output wire [7:0]  host_tx_data,
  output wire        host_tx_valid,
  input  wire        host_tx_ready,
  // radio transmit side, frame bytes from length field onwards
  output reg  [7:0]  radio_tx_data,
  output reg         radio_tx_valid,
  output reg         radio_tx_last,
  input  wire        radio_tx_ready,
  input  wire        radio_tx_done,
  input  wire        radio_tx_error,
  output reg  [7:0]  radio_mode,
  output wire        radio_sleep,
  // received frame, crc stripped and length corrected
  input  wire [7:0]  radio_rx_data,
  input  wire        radio_rx_valid,
  input  wire        radio_rx_last,
  input  wire [7:0]  radio_rx_level,
  // soft reset pulse to the rest of the module
  output reg         soft_reset
);
  localparam P_SFD  = 7'b0000001;
  localparam P_CODE = 7'b0000010;
  localparam P_LEN  = 7'b0000100;
  localparam P_DATA = 7'b0001000;
  localparam P_CS   = 7'b0010000;
  localparam P_EXEC = 7'b0100000;
  localparam P_RADIO = 7'b1000000;

  function is_tx_only;
    input [7:0] m;
    is_tx_only = (m == `RMC_MODE_S1M) | (m == `RMC_MODE_T1M) | (m == `RMC_MODE_C1M);
  endfunction
  function is_mode_ok;
    input [7:0] m;
    is_mode_ok = is_tx_only(m) | (m == `RMC_MODE_C2T2O) | (m == `RMC_MODE_S2) |
                 (m == `RMC_MODE_T2M) | (m == `RMC_MODE_T2O) |
                 (m == `RMC_MODE_C2M) | (m == `RMC_MODE_C2O);
  endfunction

  reg  [7:0] ctrl_q;
  reg  [7:0] presel_q;
  reg  [7:0] maxlen_q;
  reg  [7:0] result_q;
  reg  [15:0] cmdcnt_q;
  reg  [6:0] ps_q;
  reg  [7:0] code_q;
  reg  [7:0] len_q;
  reg  [7:0] cnt_q;
  reg  [7:0] arg_q;
  reg  [7:0] xor_q;
  reg        bad_q;
  reg        reset_pend_q;
  reg  [7:0] rx_buf [0:255];
  reg  [7:0] rx_len_q;
  reg  [7:0] rx_wr_q;
  reg        rx_full_q;
  reg        ind_pend_q;
  reg        ind_act_q;
  reg  [7:0] rx_lvl_q;
  reg        cnf_req_q;
  reg  [7:0] cnf_code_q;
  reg  [7:0] cnf_st_q;
  reg        aw_q;
  reg        w_q;
  reg  [7:0] aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0] w_strb_q;
  wire       fx_busy;
  wire       fx_done;
  wire [7:0] fx_idx;
  wire       fx_start;
  wire       fx_ind;
  wire       rx_take;

  assign radio_sleep   = is_tx_only(radio_mode) & ~radio_tx_valid;
  assign host_rx_ready = ~ps_q[5] & ~ps_q[6] & ~cnf_req_q & ~reset_pend_q &
                         ~(radio_tx_valid & ~radio_tx_ready);
  assign rx_take       = host_rx_valid & host_rx_ready;
  // indications may go out between a request and its confirmation
  assign fx_ind   = ind_pend_q & ~cnf_req_q;
  assign fx_start = ~fx_busy & ~ind_act_q & (cnf_req_q | ind_pend_q);

  // command parser
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ps_q <= P_SFD; code_q <= 8'h00; len_q <= 8'h00; cnt_q <= 8'h00;
      arg_q <= 8'h00; xor_q <= 8'h00; bad_q <= 1'b0;
      radio_mode <= `RMC_PRESEL_RESET; reset_pend_q <= 1'b0; soft_reset <= 1'b0;
      cnf_req_q <= 1'b0; cnf_code_q <= 8'h00; cnf_st_q <= 8'h00;
      radio_tx_data <= 8'h00; radio_tx_valid <= 1'b0; radio_tx_last <= 1'b0;
      result_q <= 8'h00; cmdcnt_q <= 16'h0000;
    end
    else
    begin
      soft_reset <= 1'b0;
      if (fx_start && !fx_ind)
        cnf_req_q <= 1'b0;
      if (radio_tx_valid && radio_tx_ready)
        radio_tx_valid <= 1'b0;
      // soft reset only after its confirmation has fully left
      if (reset_pend_q && !cnf_req_q && !fx_busy)
      begin
        soft_reset   <= 1'b1;
        reset_pend_q <= 1'b0;
        radio_mode   <= presel_q;
      end
      case (ps_q)
        P_SFD:
          if (rx_take && host_rx_data == `RMC_SFD)
          begin
            ps_q <= P_CODE; xor_q <= `RMC_SFD; bad_q <= 1'b0; cnt_q <= 8'h00;
          end
        P_CODE:
          if (rx_take)
          begin
            code_q <= host_rx_data; xor_q <= xor_q ^ host_rx_data;
            ps_q <= P_LEN;
          end
        P_LEN:
          if (rx_take)
          begin
            // transmit carries no length byte: the radio length field is it
            len_q <= host_rx_data; xor_q <= xor_q ^ host_rx_data;
            if (code_q == `RMC_CMD_TX)
            begin
              if (host_rx_data < `RMC_LEN_MIN || host_rx_data > maxlen_q ||
                  radio_mode == `RMC_MODE_C2T2O)
                bad_q <= 1'b1;
              else
              begin
                radio_tx_data <= host_rx_data; radio_tx_valid <= 1'b1;
                radio_tx_last <= 1'b0;
              end
            end
            ps_q <= (host_rx_data == 8'h00) ? P_CS : P_DATA;
          end
        P_DATA:
          if (rx_take)
          begin
            xor_q <= xor_q ^ host_rx_data; cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'h00) arg_q <= host_rx_data;
            if (code_q == `RMC_CMD_TX && !bad_q)
            begin
              radio_tx_data  <= host_rx_data;
              radio_tx_valid <= 1'b1;
              radio_tx_last  <= (cnt_q + 8'h01 == len_q);
            end
            if (cnt_q + 8'h01 == len_q) ps_q <= P_CS;
          end
        P_CS:
          if (rx_take)
          begin
            cmdcnt_q <= cmdcnt_q + 16'h0001;
            if ((xor_q ^ host_rx_data) != 8'h00) ps_q <= P_SFD;
            else if (code_q == `RMC_CMD_TX && !bad_q) ps_q <= P_RADIO;
            else ps_q <= P_EXEC;
          end
        P_RADIO:
          if (radio_tx_done)
          begin
            cnf_req_q <= 1'b1; cnf_code_q <= `RMC_CMD_TX | `RMC_CNF_BIT;
            cnf_st_q  <= (radio_tx_error | ctrl_q[`RMC_CTRL_TX_FAIL]) ?
                         `RMC_ST_FAIL : `RMC_ST_OK;
            result_q  <= radio_tx_error ? `RMC_ST_FAIL : `RMC_ST_OK;
            ps_q <= P_SFD;
          end
        P_EXEC:
        begin
          cnf_req_q  <= 1'b1;
          cnf_code_q <= code_q | `RMC_CNF_BIT;
          cnf_st_q   <= `RMC_ST_OK;
          case (code_q)
            `RMC_CMD_TX: cnf_st_q <= `RMC_ST_INVALID;
            `RMC_CMD_MODE:
              if (len_q == `RMC_LEN_ONE && is_mode_ok(arg_q))
                radio_mode <= arg_q;
              else
                cnf_st_q <= `RMC_ST_FAIL;
            `RMC_CMD_RESTART: reset_pend_q <= 1'b1;
            `RMC_CMD_NV_WRITE, `RMC_CMD_RATE, `RMC_CMD_NV_READ, `RMC_CMD_UNIT_NO,
            `RMC_CMD_FW_VER, `RMC_CMD_SIG_LVL, `RMC_CMD_KEY_REG,
            `RMC_CMD_KEY_UNREG, `RMC_CMD_KEY_LIST:
              cnf_st_q <= `RMC_ST_FAIL;
            default: cnf_st_q <= `RMC_ST_INVALID;
          endcase
          result_q <= code_q;
          ps_q <= P_SFD;
        end
        default: ps_q <= P_SFD;
      endcase
    end
  end

  // received frame capture: buffer written whenever not full, frame counted and indicated only when command output is on
  always @(posedge aclk)
  begin
    if (radio_rx_valid && !rx_full_q)
      rx_buf[rx_wr_q] <= radio_rx_data;
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_wr_q <= 8'h00; rx_len_q <= 8'h00; rx_full_q <= 1'b0;
      ind_pend_q <= 1'b0; ind_act_q <= 1'b0; rx_lvl_q <= 8'h00;
    end
    else
    begin
      if (fx_start && fx_ind) ind_act_q <= 1'b1;
      if (fx_start && fx_ind) ind_pend_q <= 1'b0;
      if (fx_done && ind_act_q)
      begin
        ind_act_q <= 1'b0; rx_full_q <= 1'b0; rx_wr_q <= 8'h00;
      end
      else if (radio_rx_valid && !rx_full_q && ctrl_q[`RMC_CTRL_OUT_EN])
      begin
        // first byte is the length field, already fixed upstream
        if (rx_wr_q == 8'h00) rx_len_q <= radio_rx_data;
        rx_wr_q <= rx_wr_q + 8'h01;
        if (radio_rx_last)
        begin
          rx_full_q <= 1'b1; ind_pend_q <= 1'b1; rx_lvl_q <= radio_rx_level;
        end
      end
    end
  end

  rmc_frame_tx u_tx
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .start      (fx_start),
    .code       (fx_ind ? `RMC_CMD_RX_IND : cnf_code_q),
    .len        (fx_ind ? rx_len_q : `RMC_LEN_ONE),
    .is_ind     (fx_ind | ind_act_q),
    .sig_app    (ctrl_q[`RMC_CTRL_SIG_APP]),
    .status     (cnf_st_q),
    .sig_level  (rx_lvl_q),
    .busy       (fx_busy),
    .done       (fx_done),
    .pay_idx_q  (fx_idx),
    .pay_byte   (rx_buf[fx_idx + 8'h01]),
    .out_data_q (host_tx_data),
    .out_valid_q(host_tx_valid),
    .out_ready  (host_tx_ready)
  );

  // axi4-lite slave, one write and one read at a time
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0; w_q <= 1'b0; aw_addr_q <= 8'h00; w_data_q <= 32'h0;
      w_strb_q <= 4'h0; s_axi_bvalid <= 1'b0; s_axi_bresp <= `RMC_AXI_OKAY;
      s_axi_rvalid <= 1'b0; s_axi_rresp <= `RMC_AXI_OKAY; s_axi_rdata <= 32'h0;
      ctrl_q <= `RMC_CTRL_RESET; presel_q <= `RMC_PRESEL_RESET;
      maxlen_q <= `RMC_MAXLEN_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1; aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1; w_data_q <= s_axi_wdata; w_strb_q <= s_axi_wstrb;
      end
      if (aw_q && w_q)
      begin
        aw_q <= 1'b0; w_q <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RMC_AXI_OKAY;
        case ({aw_addr_q[7:2], 2'b00})
          `RMC_REG_CTRL:   if (w_strb_q[0]) ctrl_q <= w_data_q[7:0];
          `RMC_REG_MODE:   if (w_strb_q[0]) presel_q <= w_data_q[7:0];
          `RMC_REG_MAXLEN: if (w_strb_q[0]) maxlen_q <= w_data_q[7:0];
          `RMC_REG_STATUS, `RMC_REG_RESULT, `RMC_REG_CMDCNT: ;
          default: s_axi_bresp <= `RMC_AXI_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1; s_axi_rresp <= `RMC_AXI_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          `RMC_REG_CTRL:   s_axi_rdata <= {24'h0, ctrl_q};
          `RMC_REG_STATUS: s_axi_rdata <= {16'h0, radio_mode, 1'b0, ps_q};
          `RMC_REG_MODE:   s_axi_rdata <= {24'h0, presel_q};
          `RMC_REG_RESULT: s_axi_rdata <= {24'h0, result_q};
          `RMC_REG_MAXLEN: s_axi_rdata <= {24'h0, maxlen_q};
          `RMC_REG_CMDCNT: s_axi_rdata <= {16'h0, cmdcnt_q};
          default:
          begin
            s_axi_rdata <= 32'h0; s_axi_rresp <= `RMC_AXI_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // rmc_cmd_interp
`default_nettype wire

// ---- tb/rmc_checker.sv ----
// assertion checker for the command interpreter ports
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module rmc_checker
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus read side
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // host answer stream
  input wire logic [7:0]  host_tx_data,
  input wire logic        host_tx_valid,
  input wire logic        host_tx_ready,
  // radio side
  input wire logic [7:0]  radio_tx_data,
  input wire logic        radio_tx_valid,
  input wire logic        radio_tx_ready,
  input wire logic [7:0]  radio_mode,
  input wire logic        radio_sleep,
  input wire logic        soft_reset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read address taken but no read data next cycle");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");
  a_host_hold: assert property (host_tx_valid && !host_tx_ready
    |=> host_tx_valid && $stable(host_tx_data))
    else $error("answer byte dropped or changed while stalled");
  a_radio_hold: assert property (
    radio_tx_valid && !radio_tx_ready |=> radio_tx_valid && $stable(radio_tx_data))
    else $error("radio byte dropped or changed while stalled");
  a_sleep_mode: assert property (
    radio_sleep |-> radio_mode inside {`RMC_MODE_S1M, `RMC_MODE_T1M, `RMC_MODE_C1M})
    else $error("radio asleep outside a transmit-only mode");
  a_sleep_idle: assert property (radio_sleep |-> !radio_tx_valid)
    else $error("radio asleep with a byte pending");
  a_pulse_once: assert property ($rose(soft_reset) |=> !soft_reset)
    else $error("soft reset pulse longer than one cycle");
  a_reset_after: assert property (soft_reset |-> !host_tx_valid)
    else $error("soft reset while an answer byte is still pending");
  a_mode_default: assert property (disable iff (1'b0)
    !aresetn |=> radio_mode == `RMC_PRESEL_RESET)
    else $error("radio mode not at its preselected value after reset");
endmodule // rmc_checker

bind rmc_cmd_interp rmc_checker i_rmc_checker (.*);
`default_nettype wire

// ---- tb/rmc_host_model.sv ----
// host side model: sends command frames and collects answer bytes
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model
(
  // clock
  input  wire logic       aclk,
  // command stream to the block
  output var  logic [7:0] host_rx_data,
  output var  logic       host_rx_valid,
  input  wire logic       host_rx_ready,
  // answer stream from the block
  input  wire logic [7:0] host_tx_data,
  input  wire logic       host_tx_valid,
  output var  logic       host_tx_ready,
  // stall answers every other cycle
  input  wire logic       slow
);
  logic [7:0] rxq[$];
  initial
  begin
    host_rx_data = 8'h00;
    host_rx_valid = 1'b0;
    host_tx_ready = 1'b1;
  end
  always @(posedge aclk)
  begin
    host_tx_ready <= slow ? ~host_tx_ready : 1'b1;
    if (host_tx_valid && host_tx_ready)
      rxq.push_back(host_tx_data);
  end
  // frame given from the code on; start byte and checksum added here
  task send(input logic [7:0] f[$]);
    logic [7:0] cs;
    f.push_front(8'hFF);
    cs = 8'h00;
    foreach (f[i]) cs ^= f[i];
    f.push_back(cs);
    @(posedge aclk);
    foreach (f[i])
    begin
      host_rx_data <= f[i];
      host_rx_valid <= 1'b1;
      @(posedge aclk iff host_rx_ready);
    end
    host_rx_valid <= 1'b0;
    host_rx_data <= ~host_rx_data;
  endtask
endmodule // rmc_host_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking testbench of the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module testbench;
  typedef logic [7:0] rmc_bq_t[$];
  typedef struct {logic [7:0] code; logic [7:0] len; logic [7:0] arg; logic [7:0] st;} rmc_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  host_rx_data, host_tx_data, radio_tx_data, radio_mode;
  logic        host_rx_valid, host_rx_ready, host_tx_valid, host_tx_ready;
  logic        radio_tx_valid, radio_tx_last, radio_sleep, soft_reset;
  logic        radio_tx_ready = 1'b0;
  logic        radio_tx_done = 1'b0;
  logic        radio_tx_error = 1'b0;
  logic [7:0]  radio_rx_data = 8'h00;
  logic        radio_rx_valid = 1'b0;
  logic        radio_rx_last = 1'b0;
  logic [7:0]  radio_rx_level = 8'h5A;
  logic        slow = 1'b1;
  int          errors = 0;
  int          checks_done = 0;
  rmc_bq_t     radq, q, p;
  logic [31:0] d;
  logic [1:0]  r;
  rmc_row_t rows[18] = '{
    '{8'h04, 8'h01, 8'h02, 8'h00}, '{8'h04, 8'h01, 8'h03, 8'h00},
    '{8'h04, 8'h01, 8'h07, 8'h00}, '{8'h04, 8'h01, 8'h08, 8'h00},
    '{8'h04, 8'h01, 8'h09, 8'h00}, '{8'h04, 8'h01, 8'h0C, 8'h00},
    '{8'h04, 8'h01, 8'h0D, 8'h00}, '{8'h04, 8'h01, 8'h0E, 8'h00},
    '{8'h04, 8'h01, 8'h05, 8'h00}, '{8'h09, 8'h00, 8'h00, 8'h01},
    '{8'h10, 8'h00, 8'h00, 8'h01}, '{8'h0A, 8'h00, 8'h00, 8'h01},
    '{8'h0B, 8'h00, 8'h00, 8'h01}, '{8'h0C, 8'h00, 8'h00, 8'h01},
    '{8'h0D, 8'h00, 8'h00, 8'h01}, '{8'h50, 8'h00, 8'h00, 8'h01},
    '{8'h51, 8'h00, 8'h00, 8'h01}, '{8'h52, 8'h00, 8'h00, 8'h01}};

  rmc_cmd_interp i_rmc_cmd_interp (.*);
  rmc_host_model i_rmc_host_model (.*);

  always #12.5 aclk = ~aclk;

  // radio transmitter: stalls every other cycle, reports done after the last byte
  always @(posedge aclk)
  begin
    radio_tx_ready <= ~radio_tx_ready;
    radio_tx_done <= radio_tx_valid && radio_tx_ready && radio_tx_last;
    if (radio_tx_valid && radio_tx_ready)
      radq.push_back(radio_tx_data);
  end

  task test_done;
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic rmc_bq_t framed(rmc_bq_t f);
    logic [7:0] cs;
    f.push_front(`RMC_SFD);
    cs = 8'h00;
    foreach (f[i]) cs ^= f[i];
    f.push_back(cs);
    return f;
  endfunction

  task want_frame(input rmc_bq_t f);
    int n;
    n = 0;
    while (i_rmc_host_model.rxq.size() < f.size() && n < 4000)
    begin
      @(posedge aclk);
      n++;
    end
    check(i_rmc_host_model.rxq.size() >= f.size(), 1);
    foreach (f[i])
      if (i_rmc_host_model.rxq.size() > 0)
        check(i_rmc_host_model.rxq.pop_front(), f[i]);
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        @(posedge aclk iff s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        @(posedge aclk iff s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    @(posedge aclk iff s_axi_bvalid);
    check(s_axi_bresp, `RMC_AXI_OKAY);
    s_axi_bready <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk iff s_axi_rvalid);
    check(s_axi_rdata, v);
    check(s_axi_rresp, rs);
    s_axi_rready <= 1'b0;
  endtask

  task send_rx(input rmc_bq_t f);
    foreach (f[i])
    begin
      @(posedge aclk);
      radio_rx_data <= f[i];
      radio_rx_valid <= 1'b1;
      radio_rx_last <= (i == f.size() - 1);
    end
    @(posedge aclk);
    radio_rx_valid <= 1'b0;
    radio_rx_last <= 1'b0;
    radio_rx_data <= ~radio_rx_data;
  endtask

  initial
  begin
    #2000000;
    errors++;
    test_done;
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`RMC_REG_CTRL, 32'h0, `RMC_AXI_OKAY);
    rd_chk(`RMC_REG_MODE, 32'h03, `RMC_AXI_OKAY);
    rd_chk(`RMC_REG_MAXLEN, 32'hF6, `RMC_AXI_OKAY);
    rd_chk(8'h40, 32'h0, `RMC_AXI_SLVERR);
    foreach (rows[i])
    begin
      q = '{rows[i].code, rows[i].len};
      if (rows[i].len != 8'h00)
        q.push_back(rows[i].arg);
      i_rmc_host_model.send(q);
      q = '{rows[i].code | `RMC_CNF_BIT, `RMC_LEN_ONE, rows[i].st};
      want_frame(framed(q));
      if (rows[i].len != 8'h00)
        check(radio_mode, rows[i].arg);
    end
    // transmit in a transmit-only mode, then with a radio failure
    slow <= 1'b0;
    check(radio_sleep, 1'b1);
    q = '{`RMC_CMD_TX, `RMC_LEN_MIN};
    for (int i = 1; i <= 9; i++)
      q.push_back(8'h10 + i[7:0]);
    i_rmc_host_model.send(q);
    want_frame(framed('{8'h80, 8'h01, 8'h00}));
    check(radq.size(), 10);
    foreach (radq[i]) check(radq[i], q[i + 1]);
    radio_tx_error <= 1'b1;
    i_rmc_host_model.send(q);
    want_frame(framed('{8'h80, 8'h01, 8'h01}));
    radio_tx_error <= 1'b0;
    // received frames in a bidirectional mode
    i_rmc_host_model.send('{8'h04, 8'h01, 8'h03});
    want_frame(framed('{8'h84, 8'h01, 8'h00}));
    p = '{8'h09};
    for (int i = 0; i < 9; i++)
      p.push_back(8'hA0 + i[7:0]);
    axi_wr(`RMC_REG_CTRL, 32'h1);
    send_rx(p);
    q = {8'h03, p};
    want_frame(framed(q));
    axi_wr(`RMC_REG_CTRL, 32'h3);
    send_rx(p);
    q = {8'h03, 8'h0A, p[1:$], 8'h5A};
    want_frame(framed(q));
    axi_wr(`RMC_REG_CTRL, 32'h0);
    send_rx(p);
    repeat (100) @(posedge aclk);
    check(i_rmc_host_model.rxq.size(), 0);
    // soft reset with a stalling host: confirmation fully out before the pulse
    slow <= 1'b1;
    axi_wr(`RMC_REG_MODE, 32'h0C);
    i_rmc_host_model.send('{`RMC_CMD_RESTART, 8'h00});
    @(posedge aclk iff soft_reset);
    check(i_rmc_host_model.rxq.size(), 5);
    want_frame('{8'hFF, 8'h85, 8'h01, 8'h00, 8'h7B});
    repeat (3) @(posedge aclk);
    check(radio_mode, 8'h0C);
    // every checksum-ended frame so far: 18 rows, 2 transmits, 1 mode, 1 reset
    rd_chk(`RMC_REG_CMDCNT, 32'h16, `RMC_AXI_OKAY);
    test_done;
  end
endmodule // testbench
`default_nettype wire
